// ### rtl/mras_top.sv
// Region attribute and size register with region table and access checker
//
// Overview of operation
// - Region field of base-address read returns the selected region number.
// - Attribute-and-size register addresses the region the selection register picks.
// - Word and halfword writes; upper half attributes, lower half size and enables.
// - Execute-never bit 28: zero allows fetches, one forbids them.
// - Permission, type-extension, shareable, cacheable, bufferable bits stored and read back.
// - Each subregion-disable bit, when one, disables one eighth of the region.
// - Regions of 128 bytes or less have no subregions; software writes zero.
// - Region size is two to the power of size code plus one.
// - Alignment exponent is size code plus one; code 31 covers everything.
// - Bit 0 enables the region; clear means it is never matched.
// - Eight regions; the selection register holds only 0 to 7.
// - Base write with valid set also loads the selection register.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module mras_top
  import mras_pkg::*;
#(
  parameter int NREG = 8
) (
  // Clock, reset, enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [1:0]  i_wr_half,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata_q,
  // Access check
  input  wire logic        i_acc_valid,
  input  wire mras_acc_s   i_acc,
  output logic             o_acc_done_q,
  output logic             o_acc_fault_q,
  output logic             o_acc_hit_q,
  output logic [2:0]       o_acc_region_q,
  output mras_attr_s       o_acc_attr_q,
  // Interrupt
  output logic             o_irq
);
  // ============================================================
  // Storage
  logic [31:0] ctrl_q;
  logic [2:0]  rnr_q;
  logic [31:0] faddr_q;
  mras_attr_s  attr_q [NREG];
  logic [31:0] base_q [NREG];
  logic [`MRAS_NUM_IRQ-1:0] stat_q;
  logic [`MRAS_NUM_IRQ-1:0] mask_q;

  // ============================================================
  // Decode
  wire logic sel_ctrl  = i_addr == `MRAS_OFF_CTRL;
  wire logic sel_rnr   = i_addr == `MRAS_OFF_RNR;
  wire logic sel_rbar  = i_addr == `MRAS_OFF_RBAR;
  wire logic sel_rasr  = i_addr == `MRAS_OFF_RASR;
  wire logic sel_stat  = i_addr == `MRAS_OFF_STAT;
  wire logic sel_mask  = i_addr == `MRAS_OFF_MASK;
  wire logic sel_faddr = i_addr == `MRAS_OFF_FADDR;

  wire logic wr_rbar   = i_wr && sel_rbar;
  wire logic wr_rasr   = i_wr && sel_rasr;
  wire logic rbar_vld  = i_wdata[`MRAS_RBAR_VALID];
  // Only three bits are kept, so the selection can never leave 0 to 7
  wire logic [2:0] rbar_reg = i_wdata[2:0];
  wire logic [2:0] base_idx = rbar_vld ? rbar_reg : rnr_q;

  // Halfword merge of the selected attribute word
  wire mras_attr_s cur_attr  = attr_q[rnr_q];
  wire logic [31:0] hw_mask  = {{16{i_wr_half[1]}}, {16{i_wr_half[0]}}};
  wire logic [31:0] attr_new = ((cur_attr & ~hw_mask) | (i_wdata & hw_mask))
                               & `MRAS_RASR_MASK;

  // Base readback shows only the bits at or above the alignment exponent
  wire logic [31:0] cur_base = base_q[rnr_q] & mras_region_mask(cur_attr.size);
  wire logic [31:0] rbar_rd  = {cur_base[31:5], 1'b0, 1'b0, rnr_q};

  wire logic [31:0] rd_d =
    sel_ctrl  ? ctrl_q :
    sel_rnr   ? {29'h0, rnr_q} :
    sel_rbar  ? rbar_rd :
    sel_rasr  ? 32'(cur_attr) :
    sel_stat  ? {30'h0, stat_q} :
    sel_mask  ? {30'h0, mask_q} :
    sel_faddr ? faddr_q : `MRAS_RST_WORD;

  // ============================================================
  // Register writes
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_q    <= `MRAS_RST_WORD;
      rnr_q     <= `MRAS_RST_RNR;
      o_rdata_q <= `MRAS_RST_WORD;
    end else if (i_ce) begin
      if (i_wr && sel_ctrl) begin
        ctrl_q <= i_wdata & ((32'h1 << `MRAS_CTRL_EN_BIT) | (32'h1 << `MRAS_CTRL_PDEF_BIT));
      end
      if (i_wr && sel_rnr) begin
        rnr_q <= i_wdata[2:0];
      end else if (wr_rbar && rbar_vld) begin
        rnr_q <= rbar_reg;
      end
      o_rdata_q <= i_rd ? rd_d : `MRAS_RST_WORD;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int k = 0; k < NREG; k++) begin
        attr_q[k] <= mras_attr_s'(`MRAS_RST_WORD);
        base_q[k] <= `MRAS_RST_WORD;
      end
    end else if (i_ce) begin
      if (wr_rasr) begin
        attr_q[rnr_q] <= mras_attr_s'(attr_new);
      end
      // Base kept from bit 5 up; alignment is software's job, mask applied on use
      if (wr_rbar) begin
        base_q[base_idx] <= i_wdata & `MRAS_RBAR_ADDR_MSK;
      end
    end
  end

  // ============================================================
  // Region matching
  logic [NREG-1:0] hit;
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    mras_region_match u_match (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_attr    (attr_q[g]),
      .i_base    (base_q[g]),
      .i_addr    (i_acc.addr),
      .o_hit     (hit[g])
    );
  end

  // Highest-numbered matching region wins
  function automatic logic [2:0] win_of(input logic [NREG-1:0] h);
    logic [2:0] w;
    w = 3'h0;
    for (int k = 0; k < NREG; k++) begin
      if (h[k]) begin
        w = 3'(k);
      end
    end
    return w;
  endfunction

  wire logic       mpu_en   = ctrl_q[`MRAS_CTRL_EN_BIT];
  wire logic       pdef_en  = ctrl_q[`MRAS_CTRL_PDEF_BIT];
  wire logic       any_hit  = |hit;
  wire logic [2:0] win      = win_of(hit);
  wire mras_attr_s win_attr = attr_q[win];
  wire logic       xn_fault = any_hit && i_acc.fetch && win_attr.execute_never;
  wire logic       nomap    = !any_hit && !(pdef_en && i_acc.priv);
  wire logic       chk      = i_ce && i_acc_valid && mpu_en;
  wire logic       ev_xn    = chk && xn_fault;
  wire logic       ev_nomap = chk && nomap;

  // ============================================================
  // Access result, one cycle after the request
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_acc_done_q   <= 1'b0;
      o_acc_fault_q  <= 1'b0;
      o_acc_hit_q    <= 1'b0;
      o_acc_region_q <= 3'h0;
      o_acc_attr_q   <= mras_attr_s'(`MRAS_RST_WORD);
      faddr_q        <= `MRAS_RST_WORD;
    end else if (i_ce) begin
      o_acc_done_q   <= i_acc_valid;
      o_acc_fault_q  <= ev_xn || ev_nomap;
      o_acc_hit_q    <= i_acc_valid && any_hit;
      o_acc_region_q <= win;
      o_acc_attr_q   <= any_hit ? win_attr : mras_attr_s'(`MRAS_RST_WORD);
      if (ev_xn || ev_nomap) begin
        faddr_q <= i_acc.addr;
      end
    end
  end

  // ============================================================
  // Interrupt
  wire logic [`MRAS_NUM_IRQ-1:0] ev_set = {ev_nomap, ev_xn};
  wire logic [`MRAS_NUM_IRQ-1:0] ev_clr = (i_wr && sel_stat) ? i_wdata[`MRAS_NUM_IRQ-1:0] : '0;

  mras_irq #(
    .N (`MRAS_NUM_IRQ)
  ) u_irq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_set     (ev_set),
    .i_clr     (ev_clr),
    .i_mask_we (i_wr && sel_mask),
    .i_mask_d  (i_wdata[`MRAS_NUM_IRQ-1:0]),
    .o_stat_q  (stat_q),
    .o_mask_q  (mask_q),
    .o_irq     (o_irq)
  );

  // ============================================================
  // Checks
  sequence s_rbar_rd;
    i_ce && i_rd && sel_rbar;
  endsequence

  property p_rnr_rd;
    @(posedge i_clk_sys) disable iff (i_rst) s_rbar_rd |=> o_rdata_q[2:0] == $past(rnr_q);
  endproperty
  a_rnr_rd: assert property (p_rnr_rd) else $error("region field readback wrong");

  property p_valid_load;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && wr_rbar && rbar_vld |=> rnr_q == $past(i_wdata[2:0]);
  endproperty
  a_valid_load: assert property (p_valid_load) else $error("valid write missed selection");

  property p_valid_clr;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && wr_rbar && !rbar_vld |=> $stable(rnr_q);
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("selection moved on plain write");

  property p_half_lo;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && wr_rasr && i_wr_half == 2'b01 |=>
        cur_attr[31:16] == $past(cur_attr[31:16]) && cur_attr[15:0] == $past(attr_new[15:0]);
  endproperty
  a_half_lo: assert property (p_half_lo) else $error("low halfword write disturbed upper");

  property p_rsv_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && i_rd && sel_rasr |=> (o_rdata_q & ~`MRAS_RASR_MASK) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved attribute bits set");

  sequence s_xn_fetch;
    chk && i_acc.fetch && any_hit && win_attr.execute_never;
  endsequence

  property p_xn_fault;
    @(posedge i_clk_sys) disable iff (i_rst) s_xn_fetch |=> o_acc_fault_q ##0 stat_q[`MRAS_STAT_XN];
  endproperty
  a_xn_fault: assert property (p_xn_fault) else $error("execute-never fetch not faulted");

  property p_xn_ok;
    @(posedge i_clk_sys) disable iff (i_rst)
      chk && any_hit && !win_attr.execute_never |=> !o_acc_fault_q;
  endproperty
  a_xn_ok: assert property (p_xn_ok) else $error("allowed access faulted");

  property p_nomap;
    @(posedge i_clk_sys) disable iff (i_rst)
      chk && !any_hit && !(pdef_en && i_acc.priv) |=> o_acc_fault_q && !o_acc_hit_q;
  endproperty
  a_nomap: assert property (p_nomap) else $error("unmatched access not faulted");

  property p_rnr_wr;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && i_wr && sel_rnr |=> rnr_q == $past(i_wdata[2:0]);
  endproperty
  a_rnr_wr: assert property (p_rnr_wr) else $error("selection write lost");

  property p_valid_rd0;
    @(posedge i_clk_sys) disable iff (i_rst) s_rbar_rd |=> !o_rdata_q[`MRAS_RBAR_VALID];
  endproperty
  a_valid_rd0: assert property (p_valid_rd0) else $error("valid bit read back set");

  property p_half_hi;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && wr_rasr && i_wr_half == 2'b10 |=>
        cur_attr[15:0] == $past(cur_attr[15:0]) && cur_attr[31:16] == $past(attr_new[31:16]);
  endproperty
  a_half_hi: assert property (p_half_hi) else $error("upper halfword write disturbed lower");

  // Winner and its attributes must be the ones seen at the request edge
  sequence s_acc_hit;
    i_ce && i_acc_valid && any_hit;
  endsequence

  property p_acc_win;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_acc_hit |=> o_acc_hit_q && o_acc_region_q == $past(win) && o_acc_attr_q == $past(win_attr);
  endproperty
  a_acc_win: assert property (p_acc_win) else $error("winning region result wrong");

  property p_xn_data;
    @(posedge i_clk_sys) disable iff (i_rst)
      chk && !i_acc.fetch && any_hit |=> !o_acc_fault_q;
  endproperty
  a_xn_data: assert property (p_xn_data) else $error("data access hit by execute-never");

  // A low enable must freeze selection, read data and status alike
  property p_ce_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      !i_ce |=> $stable(rnr_q) && $stable(o_rdata_q) && $stable(stat_q);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved while enable low");

  property p_fault_addr;
    @(posedge i_clk_sys) disable iff (i_rst)
      chk && (xn_fault || nomap) |=> faddr_q == $past(i_acc.addr);
  endproperty
  a_fault_addr: assert property (p_fault_addr) else $error("fault address not captured");
endmodule

// ### include/mras_cfg.svh
// Constants for the region attribute and size register block
`ifndef MRAS_CFG_SVH
`define MRAS_CFG_SVH
// ============================================================
// Register offsets (byte addresses)
`define MRAS_OFF_CTRL      8'h00
`define MRAS_OFF_RNR       8'h04
`define MRAS_OFF_RBAR      8'h08
`define MRAS_OFF_RASR      8'h0c
`define MRAS_OFF_STAT      8'h10
`define MRAS_OFF_MASK      8'h14
`define MRAS_OFF_FADDR     8'h18
// ============================================================
// Field positions and masks
`define MRAS_CTRL_EN_BIT   0
`define MRAS_CTRL_PDEF_BIT 2
`define MRAS_RBAR_VALID    4
`define MRAS_RBAR_ADDR_MSK 32'hffffffe0
`define MRAS_RASR_MASK     32'h173fff3f
`define MRAS_STAT_XN       0
`define MRAS_STAT_NOMAP    1
// ============================================================
// Reset values and size codes
`define MRAS_RST_WORD      32'h00000000
`define MRAS_RST_RNR       3'h0
`define MRAS_SIZE_NOSUB    5'h06
`define MRAS_SIZE_FULL     5'h1f
`define MRAS_SUB_DROP      5'h02
`define MRAS_NUM_IRQ       2
`endif

// ### include/mras_pkg.sv
// Types and shared functions for the region attribute and size register block
package mras_pkg;
  `include "mras_cfg.svh"

  // ============================================================
  // Attribute-and-size word layout
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       execute_never;
    logic       rsv_b27;
    logic [2:0] access_permission;
    logic [1:0] rsv_mid;
    logic [2:0] type_extension;
    logic       shareable;
    logic       cacheable;
    logic       bufferable;
    logic [7:0] subregion_disable;
    logic [1:0] rsv_lo;
    logic [4:0] size;
    logic       enable;
  } mras_attr_s;

  // Access presented by the core to the checker
  typedef struct packed {
    logic [31:0] addr;
    logic        fetch;
    logic        write;
    logic        priv;
  } mras_acc_s;

  // ============================================================
  // Address bits at or above the alignment exponent (size code plus one)
  function automatic logic [31:0] mras_region_mask(input logic [4:0] sz);
    logic [32:0] span;
    span = (33'h1 << ({1'b0, sz} + 6'h01)) - 33'h1;
    return ~span[31:0];
  endfunction
endpackage

// ### rtl/mras_region_match.sv
// Address match of one protection region, subregions included
`timescale 1ns/1ps
module mras_region_match
  import mras_pkg::*;
(
  // Clock and reset, used by the checks only
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Region setup
  input  wire mras_attr_s  i_attr,
  input  wire logic [31:0] i_base,
  // Access address
  input  wire logic [31:0] i_addr,
  // Result
  output logic             o_hit
);
  // ============================================================
  // Match
  wire logic [31:0] rmask   = mras_region_mask(i_attr.size);
  wire logic        base_ok = ((i_addr ^ i_base) & rmask) == 32'h0;
  wire logic [4:0]  sh      = i_attr.size - `MRAS_SUB_DROP;
  wire logic [31:0] sub_w   = i_addr >> sh;
  // Small regions have no subregions, so their disable bits are ignored
  wire logic        has_sub = i_attr.size > `MRAS_SIZE_NOSUB;
  wire logic        sub_off = has_sub && i_attr.subregion_disable[sub_w[2:0]];

  assign o_hit = i_attr.enable && base_ok && !sub_off;

  // ============================================================
  // Checks
  property p_en_off;
    @(posedge i_clk_sys) disable iff (i_rst) !i_attr.enable |-> !o_hit;
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled region matched");

  property p_small_nosub;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_attr.enable && i_attr.size <= `MRAS_SIZE_NOSUB && base_ok |-> o_hit;
  endproperty
  a_small_nosub: assert property (p_small_nosub) else $error("small region used subregions");

  property p_full_map;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_attr.enable && i_attr.size == `MRAS_SIZE_FULL && i_attr.subregion_disable == 8'h00 |-> o_hit;
  endproperty
  a_full_map: assert property (p_full_map) else $error("full map region missed");
endmodule

// ### rtl/mras_irq.sv
// Sticky event status, mask and interrupt output
`timescale 1ns/1ps
module mras_irq #(
  parameter int N = 2
) (
  // Clock and control
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Events and software access
  input  wire logic [N-1:0] i_set,
  input  wire logic [N-1:0] i_clr,
  input  wire logic         i_mask_we,
  input  wire logic [N-1:0] i_mask_d,
  // State
  output logic      [N-1:0] o_stat_q,
  output logic      [N-1:0] o_mask_q,
  output logic              o_irq
);
  // ============================================================
  // Status and mask
  // Set wins over a write-one clear in the same cycle
  wire logic [N-1:0] stat_d = (o_stat_q & ~i_clr) | i_set;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_stat_q <= '0;
      o_mask_q <= '0;
    end else if (i_ce) begin
      o_stat_q <= stat_d;
      if (i_mask_we) begin
        o_mask_q <= i_mask_d;
      end
    end
  end

  assign o_irq = |(o_stat_q & o_mask_q);

  property p_set_wins;
    @(posedge i_clk_sys) disable iff (i_rst) i_ce && i_set[0] |=> o_stat_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
endmodule

// ### sim/mras_core_model.sv
// Core model issuing one memory access at a time to the checker
`timescale 1ns/1ps
module mras_core_model
  import mras_pkg::*;
(
  // Clock
  input  wire logic        i_clk_sys,
  // Checker answer
  input  wire logic        i_done,
  input  wire logic        i_fault,
  input  wire logic        i_hit,
  input  wire logic [2:0]  i_region,
  // Access request
  output logic             o_acc_valid,
  output mras_acc_s        o_acc
);
  logic       seen_done;
  logic       seen_fault;
  logic       seen_hit;
  logic [2:0] seen_region;

  initial begin
    o_acc_valid = 1'b0;
    o_acc       = '0;
  end

  // ============================================================
  // One request, held until the edge that takes it
  task automatic issue(input logic [31:0] a, input logic f, input logic p);
    @(posedge i_clk_sys);
    o_acc_valid <= 1'b1;
    o_acc       <= '{addr: a, fetch: f, write: 1'b0, priv: p};
    @(posedge i_clk_sys);
    o_acc_valid <= 1'b0;
    // Released address must not look like a live one
    o_acc.addr  <= ~a;
    #1;
    seen_done   = i_done;
    seen_fault  = i_fault;
    seen_hit    = i_hit;
    seen_region = i_region;
  endtask
endmodule

// ### sim/mras_top_tb_top.sv
// Self-checking bench for the region attribute and size register block
`timescale 1ns/1ps
module mras_top_tb_top
  import mras_pkg::*;
;
  `include "mras_cfg.svh"
  logic        clk;
  logic        rst;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [1:0]  wr_half;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        acc_valid;
  mras_acc_s   acc;
  logic        done;
  logic        fault;
  logic        hit;
  logic [2:0]  region;
  mras_attr_s  attr;
  logic        irq;
  logic [31:0] v;
  int          n_mismatch = 0;
  int          checked    = 0;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  mras_top dut_u (
    .i_clk_sys      (clk),
    .i_rst          (rst),
    .i_ce           (ce),
    .i_addr         (addr),
    .i_wdata        (wdata),
    .i_wr_half      (wr_half),
    .i_wr           (wr),
    .i_rd           (rd),
    .o_rdata_q      (rdata),
    .i_acc_valid    (acc_valid),
    .i_acc          (acc),
    .o_acc_done_q   (done),
    .o_acc_fault_q  (fault),
    .o_acc_hit_q    (hit),
    .o_acc_region_q (region),
    .o_acc_attr_q   (attr),
    .o_irq          (irq)
  );

  mras_core_model core_u (
    .i_clk_sys   (clk),
    .i_done      (done),
    .i_fault     (fault),
    .i_hit       (hit),
    .i_region    (region),
    .o_acc_valid (acc_valid),
    .o_acc       (acc)
  );

  // ============================================================
  // Bus tasks and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] h = 2'b11);
    @(posedge clk);
    addr    <= a;
    wdata   <= d;
    wr_half <= h;
    wr      <= 1'b1;
    @(posedge clk);
    wr      <= 1'b0;
    // Let the edge's updates settle before anyone looks at outputs
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic acc_chk(input logic [31:0] a, input logic f, input logic p, input logic [2:0] exp);
    core_u.issue(a, f, p);
    chk({29'h0, core_u.seen_done, core_u.seen_hit, core_u.seen_fault}, {29'h0, 1'b1, exp[1:0]});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Tests
  initial begin
    rst     = 1'b1;
    ce      = 1'b1;
    addr    = 8'h00;
    wdata   = 32'h00000000;
    wr_half = 2'b00;
    wr      = 1'b0;
    rd      = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h00000000);
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000000);
    $display("test reset done");
    wr_reg(`MRAS_OFF_RASR, 32'hffffffff);
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h173fff3f);
    wr_reg(`MRAS_OFF_RASR, 32'h00000000, 2'b10);
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h0000ff3f);
    wr_reg(`MRAS_OFF_RASR, 32'h00000000, 2'b01);
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h00000000);
    $display("test fields done");
    wr_reg(`MRAS_OFF_RNR, 32'h0000000b);
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000003);
    wr_reg(`MRAS_OFF_RASR, 32'h05000000);
    wr_reg(`MRAS_OFF_RNR, 32'h00000000);
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h00000000);
    wr_reg(`MRAS_OFF_RNR, 32'h00000003);
    rd_reg(`MRAS_OFF_RASR, v);
    chk(v, 32'h05000000);
    // Base aligned to the 1 KB region
    wr_reg(`MRAS_OFF_RBAR, 32'h00001015);
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000005);
    // Size code kept at 4 or above
    wr_reg(`MRAS_OFF_RASR, 32'h10000013);
    rd_reg(`MRAS_OFF_RBAR, v);
    chk(v, 32'h00001005);
    wr_reg(`MRAS_OFF_RBAR, 32'h00001002);
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000005);
    $display("test select done");
    wr_reg(`MRAS_OFF_CTRL, 32'h00000001);
    wr_reg(`MRAS_OFF_MASK, 32'h00000003);
    acc_chk(32'h00001000, 1'b1, 1'b0, 3'b011);
    chk({29'h0, core_u.seen_region}, 32'h00000005);
    chk({31'h0, irq}, 32'h00000001);
    rd_reg(`MRAS_OFF_STAT, v);
    chk(v, 32'h00000001);
    acc_chk(32'h00001000, 1'b0, 1'b0, 3'b010);
    chk(attr, 32'h10000013);
    acc_chk(32'h000013fc, 1'b0, 1'b0, 3'b010);
    acc_chk(32'h00001400, 1'b0, 1'b0, 3'b001);
    rd_reg(`MRAS_OFF_FADDR, v);
    chk(v, 32'h00001400);
    wr_reg(`MRAS_OFF_STAT, 32'h00000003);
    rd_reg(`MRAS_OFF_STAT, v);
    chk(v, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    $display("test check done");
    wr_reg(`MRAS_OFF_RASR, 32'h10000213);
    acc_chk(32'h00001080, 1'b1, 1'b0, 3'b001);
    acc_chk(32'h00001000, 1'b1, 1'b0, 3'b011);
    wr_reg(`MRAS_OFF_CTRL, 32'h00000005);
    acc_chk(32'h00001080, 1'b1, 1'b1, 3'b000);
    // 128 byte region: subregion bits have no effect
    wr_reg(`MRAS_OFF_RASR, 32'h0000ff0d);
    acc_chk(32'h00001000, 1'b0, 1'b0, 3'b010);
    wr_reg(`MRAS_OFF_RASR, 32'h10000012);
    acc_chk(32'h00001000, 1'b1, 1'b0, 3'b001);
    $display("test subregion done");
    wr_reg(`MRAS_OFF_MASK, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    wr_reg(`MRAS_OFF_MASK, 32'h00000002);
    chk({31'h0, irq}, 32'h00000001);
    rd_reg(8'h1c, v);
    chk(v, 32'h00000000);
    $display("test interrupt done");
    // Write with enable low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`MRAS_OFF_RNR, 32'h00000002);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000005);
    // Reset in mid-run clears selection, status and interrupt
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`MRAS_OFF_RNR, v);
    chk(v, 32'h00000000);
    rd_reg(`MRAS_OFF_STAT, v);
    chk(v, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    $display("test freeze and reset done");
    conclude();
  end

  // Whole run needs well under 500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule
